/* inc/slsb_regs.svh */
// timing and reset constants of the simplex link startup sideband block
`ifndef SLSB_REGS_SVH
`define SLSB_REGS_SVH

// user clock rate in MHz (period 4 ns)
`define SLSB_CLK_MHZ          250
// hold time of a restart before the first phase, in cycles
`define SLSB_RESTART_CYCLES   16
// worst-case phase durations for the timer-driven send side, in us
`define SLSB_ALIGN_TIME_US    40
`define SLSB_BOND_TIME_US     40
`define SLSB_VERIFY_TIME_US   80
// receive-side phase watchdog, in us
`define SLSB_WDOG_TIME_US     400
// periodic re-initialization period of the timed send side, in ms
`define SLSB_REINIT_TIME_MS   10
// number of lanes in the default build
`define SLSB_LANES            1
// number of phase timers in the block
`define SLSB_NUM_TIMERS       7
// timer indices
`define SLSB_TIM_TX_HOLD      0
`define SLSB_TIM_ALIGN        1
`define SLSB_TIM_BOND         2
`define SLSB_TIM_VERIFY       3
`define SLSB_TIM_REINIT       4
`define SLSB_TIM_WDOG         5
`define SLSB_TIM_RX_HOLD      6
// synchronised pin inputs: 3 transceiver status, 4 back channel
`define SLSB_SYNC_W           7

`endif

/* inc/slsb_pkg.sv */
// types of the simplex link startup sideband block
package slsb_pkg;

	// send_link_startup_fsm states, one-hot
	typedef enum logic [4:0] {
		SND_RESTART = 5'h01,
		SND_ALIGN   = 5'h02,
		SND_BOND    = 5'h04,
		SND_VERIFY  = 5'h08,
		SND_READY   = 5'h10
	} slsb_send_st_t;

	// recv_link_startup_fsm states, one-hot
	typedef enum logic [4:0] {
		RCV_RESTART = 5'h01,
		RCV_ALIGN   = 5'h02,
		RCV_BOND    = 5'h04,
		RCV_VERIFY  = 5'h08,
		RCV_UP      = 5'h10
	} slsb_recv_st_t;

endpackage : slsb_pkg

/* verilog/slsb_phase_timer.sv */
// run-gated phase timer that flags expiry after a fixed number of cycles
`timescale 1ns/10ps

module slsb_phase_timer #(
	parameter int unsigned CW    = 32,
	parameter logic [31:0] LIMIT = 32'h0000_0010
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// control
	input  wire logic run,
	// status
	output logic      done
);

	logic [CW-1:0] cnt_r;

	// count while running; dropping run rearms the timer at once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (!run) begin
			cnt_r <= '0;
		end else if (cnt_r != LIMIT[CW-1:0]) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// saturates at the limit so done stays up until run falls
	assign done = run && (cnt_r == LIMIT[CW-1:0]);

endmodule // slsb_phase_timer

/* verilog/slsb_top.sv */
// simplex link startup sideband logic and transceiver status/control
// Operation
// RULE1 - send and receive sides each own align, bond, verify and reset flags
// RULE2 - bond flags only used in multi-lane builds; single-lane leaves them low
// RULE3 - option one: outside logic forwards receive flags to send inputs
// RULE4 - option two: send inputs come from timed intervals only
// RULE5 - back channel reports which receive flags are set on each change
// RULE6 - separate align, bond and verify timers preset to worst-case durations
// RULE7 - timed send flags assert on timer expiry, ignoring link state
// RULE8 - receive watchdog returns a stalled phase to restart
// RULE9 - receive fall to restart must be checked against send phase lengths
// RULE10 - watchdog duration is a build parameter
// RULE11 - initialization re-entered only on failure; the send side also restarts on re-init timer expiry and on leaving timed mode
// RULE12 - timed send side should restart initialization periodically
// RULE13 - power-down input drives transceiver power-down
// RULE14 - three-bit loopback input selects normal or loopback modes
// RULE15 - send and receive reset-done outputs mirror the transceiver's
// RULE16 - lock output shows transceiver PLL locked to reference clock
// RULE17 - send side has no receive path; it only transmits
// RULE18 - hard error resets the core and retries initialization; TX_HARD_ERR has no effect on the send flags outside timed mode
// RULE19 - timed send order align, bond, verify; restart clears them all
`timescale 1ns/10ps
`include "slsb_regs.svh"
module slsb_top #(
	parameter int unsigned LANES        = `SLSB_LANES,
	parameter logic [31:0] ALIGN_CYCLES =
		32'(`SLSB_ALIGN_TIME_US * `SLSB_CLK_MHZ),
	parameter logic [31:0] BOND_CYCLES  =
		32'(`SLSB_BOND_TIME_US * `SLSB_CLK_MHZ),
	parameter logic [31:0] VERIFY_CYCLES =
		32'(`SLSB_VERIFY_TIME_US * `SLSB_CLK_MHZ),
	parameter logic [31:0] WATCHDOG_TIMEOUT =
		32'(`SLSB_WDOG_TIME_US * `SLSB_CLK_MHZ),
	parameter logic [31:0] REINIT_CYCLES =
		32'(`SLSB_REINIT_TIME_MS * 1000 * `SLSB_CLK_MHZ)
) (
	// clock and reset
	input  wire logic       SYS_CLK,
	input  wire logic       ARST_N,
	// configuration
	input  wire logic       INIT_TIMED,
	input  wire logic       REINIT_EN,
	// back channel pins carrying the receive flags
	input  wire logic       BC_ALIGNED,
	input  wire logic       BC_BONDED,
	input  wire logic       BC_VERIFY,
	input  wire logic       BC_RESET,
	// error reports from the datapaths
	input  wire logic       TX_HARD_ERR,
	input  wire logic       RX_HARD_ERR,
	// receive lane progress from the datapath
	input  wire logic       RX_LANE_ALIGNED,
	input  wire logic       RX_LANE_BONDED,
	input  wire logic       RX_LANE_VERIFIED,
	// send-side sideband flags
	output logic            TX_ALIGNED,
	output logic            TX_BONDED,
	output logic            TX_VERIFY,
	output logic            TX_RESET,
	output logic            TX_CHANNEL_UP,
	// receive-side sideband flags
	output logic            RX_ALIGNED,
	output logic            RX_BONDED,
	output logic            RX_VERIFY,
	output logic            RX_RESET,
	output logic            RX_CHANNEL_UP,
	// transceiver control, user side
	input  wire logic       POWER_DOWN,
	input  wire logic [2:0] LOOPBACK,
	// transceiver control, transceiver side
	output logic            GT_POWER_DOWN,
	output logic [2:0]      GT_LOOPBACK,
	// transceiver status, transceiver side
	input  wire logic       GT_TX_RESETDONE,
	input  wire logic       GT_RX_RESETDONE,
	input  wire logic       GT_PLL_LOCK,
	// transceiver status, user side
	output logic            TX_RESETDONE_OUT,
	output logic            RX_RESETDONE_OUT,
	output logic            TX_LOCK
);
	localparam bit MULTI = (LANES > 1);
	logic                      rst_s1_r;
	logic                      rst_n_r;
	logic [`SLSB_SYNC_W-1:0]   sync1_r;
	logic [`SLSB_SYNC_W-1:0]   sync2_r;
	logic [`SLSB_NUM_TIMERS-1:0] tim_run;
	logic [`SLSB_NUM_TIMERS-1:0] tim_done;
	slsb_pkg::slsb_send_st_t   snd_st_r;
	slsb_pkg::slsb_send_st_t   snd_st_nxt;
	slsb_pkg::slsb_recv_st_t   rcv_st_r;
	slsb_pkg::slsb_recv_st_t   rcv_st_nxt;
	logic                      rcv_moved_r;
	logic                      bc_aligned;
	logic                      bc_bonded;
	logic                      bc_verify;
	logic                      bc_reset;
	logic                      snd_fail;
	// limit of each phase timer; a zero limit is lifted to one cycle
	function automatic logic [31:0] tim_limit(input int idx);
		logic [31:0] v;
		v = 32'h0000_0001;
		case (idx)
			`SLSB_TIM_TX_HOLD: v = 32'(`SLSB_RESTART_CYCLES);
			`SLSB_TIM_ALIGN:   v = ALIGN_CYCLES;
			`SLSB_TIM_BOND:    v = BOND_CYCLES;
			`SLSB_TIM_VERIFY:  v = VERIFY_CYCLES;
			`SLSB_TIM_REINIT:  v = REINIT_CYCLES;
			`SLSB_TIM_WDOG:    v = WATCHDOG_TIMEOUT;
			`SLSB_TIM_RX_HOLD: v = 32'(`SLSB_RESTART_CYCLES);
			default:           v = 32'h0000_0001;
		endcase
		if (v == 32'h0000_0000) begin
			v = 32'h0000_0001;
		end
		return v;
	endfunction
	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// two-flop synchronisers for transceiver status and back channel pins
	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {BC_RESET, BC_VERIFY, BC_BONDED, BC_ALIGNED,
				GT_PLL_LOCK, GT_RX_RESETDONE, GT_TX_RESETDONE};
			sync2_r <= sync1_r;
		end
	end

	// back channel view of the receive flags, as forwarded by outside logic
	assign bc_aligned = sync2_r[3]; // RULE3
	assign bc_bonded  = sync2_r[4] && MULTI; // RULE2
	assign bc_verify  = sync2_r[5]; // RULE5
	assign bc_reset   = sync2_r[6];
	// one timer per phase, each with its own preset limit
	genvar g;
	generate
		for (g = 0; g < `SLSB_NUM_TIMERS; g++) begin : g_tim
			slsb_phase_timer #(
				.CW    (32),
				.LIMIT (tim_limit(g))
			) u_tim (
				.clk   (SYS_CLK),
				.rst_n (rst_n_r),
				.run   (tim_run[g]),
				.done  (tim_done[g])
			); // RULE6
		end
	endgenerate
	// timer run terms; the watchdog rearms whenever the receive phase moves
	always_comb begin
		tim_run = '0;
		tim_run[`SLSB_TIM_TX_HOLD] = (snd_st_r == slsb_pkg::SND_RESTART);
		tim_run[`SLSB_TIM_ALIGN]   = (snd_st_r == slsb_pkg::SND_ALIGN);
		tim_run[`SLSB_TIM_BOND]    = (snd_st_r == slsb_pkg::SND_BOND);
		tim_run[`SLSB_TIM_VERIFY]  = (snd_st_r == slsb_pkg::SND_VERIFY);
		tim_run[`SLSB_TIM_REINIT]  = (snd_st_r == slsb_pkg::SND_READY) &&
			INIT_TIMED && REINIT_EN; // RULE12
		tim_run[`SLSB_TIM_WDOG]    = !rcv_moved_r &&
			((rcv_st_r == slsb_pkg::RCV_ALIGN) ||
			(rcv_st_r == slsb_pkg::RCV_BOND) ||
			(rcv_st_r == slsb_pkg::RCV_VERIFY)); // RULE10
		tim_run[`SLSB_TIM_RX_HOLD] = (rcv_st_r == slsb_pkg::RCV_RESTART);
	end

	// send failure is a hard error or the end of the re-init period; leaving timed mode is handled in the fsm
	assign snd_fail = TX_HARD_ERR || tim_done[`SLSB_TIM_REINIT]; // RULE11
	// send_link_startup_fsm: timer-driven, looks at no receive input
	always_comb begin
		snd_st_nxt = snd_st_r;
		unique case (snd_st_r)
			slsb_pkg::SND_RESTART: begin
				if (INIT_TIMED && tim_done[`SLSB_TIM_TX_HOLD]) begin
					snd_st_nxt = slsb_pkg::SND_ALIGN;
				end
			end
			slsb_pkg::SND_ALIGN: begin
				if (tim_done[`SLSB_TIM_ALIGN]) begin
					snd_st_nxt = MULTI ? slsb_pkg::SND_BOND :
						slsb_pkg::SND_VERIFY; // RULE19
				end
			end
			slsb_pkg::SND_BOND: begin
				if (tim_done[`SLSB_TIM_BOND]) begin
					snd_st_nxt = slsb_pkg::SND_VERIFY; // RULE19
				end
			end
			slsb_pkg::SND_VERIFY: begin
				if (tim_done[`SLSB_TIM_VERIFY]) begin
					snd_st_nxt = slsb_pkg::SND_READY; // RULE19
				end
			end
			slsb_pkg::SND_READY: begin
				snd_st_nxt = slsb_pkg::SND_READY;
			end
			default: snd_st_nxt = slsb_pkg::SND_RESTART;
		endcase
		// hard error or leaving timed mode forces a fresh start
		if (snd_fail || !INIT_TIMED) begin
			snd_st_nxt = slsb_pkg::SND_RESTART; // RULE18
		end
	end

	// send state register
	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			snd_st_r <= slsb_pkg::SND_RESTART;
		end else begin
			snd_st_r <= snd_st_nxt; // RULE17
		end
	end

	// send flags: own timers in timed mode, forwarded back channel otherwise
	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			TX_ALIGNED    <= 1'b0;
			TX_BONDED     <= 1'b0;
			TX_VERIFY     <= 1'b0;
			TX_RESET      <= 1'b1;
			TX_CHANNEL_UP <= 1'b0;
		end else if (INIT_TIMED) begin
			// flags follow expiry only, never the actual link state
			TX_ALIGNED    <= (snd_st_r != slsb_pkg::SND_RESTART) &&
				(snd_st_r != slsb_pkg::SND_ALIGN); // RULE7
			TX_BONDED     <= MULTI &&
				((snd_st_r == slsb_pkg::SND_VERIFY) ||
				(snd_st_r == slsb_pkg::SND_READY)); // RULE2
			TX_VERIFY     <= (snd_st_r == slsb_pkg::SND_READY); // RULE4
			TX_RESET      <= (snd_st_r == slsb_pkg::SND_RESTART); // RULE19
			TX_CHANNEL_UP <= (snd_st_r == slsb_pkg::SND_READY);
		end else begin
			TX_ALIGNED    <= bc_aligned && !bc_reset; // RULE1
			TX_BONDED     <= bc_bonded && !bc_reset;
			TX_VERIFY     <= bc_verify && !bc_reset;
			TX_RESET      <= bc_reset;
			TX_CHANNEL_UP <= bc_verify && !bc_reset;
		end
	end

	// recv_link_startup_fsm: follows lane progress, guarded by watchdog
	always_comb begin
		rcv_st_nxt = rcv_st_r;
		unique case (rcv_st_r)
			slsb_pkg::RCV_RESTART: begin
				if (tim_done[`SLSB_TIM_RX_HOLD]) begin
					rcv_st_nxt = slsb_pkg::RCV_ALIGN;
				end
			end
			slsb_pkg::RCV_ALIGN: begin
				if (RX_LANE_ALIGNED) begin
					rcv_st_nxt = MULTI ? slsb_pkg::RCV_BOND :
						slsb_pkg::RCV_VERIFY; // RULE2
				end
			end
			slsb_pkg::RCV_BOND: begin
				if (RX_LANE_BONDED) begin
					rcv_st_nxt = slsb_pkg::RCV_VERIFY;
				end
			end
			slsb_pkg::RCV_VERIFY: begin
				if (RX_LANE_VERIFIED) begin
					rcv_st_nxt = slsb_pkg::RCV_UP;
				end
			end
			slsb_pkg::RCV_UP: begin
				// losing alignment in service counts as a failure
				if (!RX_LANE_ALIGNED) begin
					rcv_st_nxt = slsb_pkg::RCV_RESTART; // RULE11
				end
			end
			default: rcv_st_nxt = slsb_pkg::RCV_RESTART;
		endcase
		// a long timed send phase can trip this; size timers below it
		if (tim_done[`SLSB_TIM_WDOG]) begin
			rcv_st_nxt = slsb_pkg::RCV_RESTART; // RULE8
		end
		if (RX_HARD_ERR) begin
			rcv_st_nxt = slsb_pkg::RCV_RESTART; // RULE18
		end
	end

	// receive state register and phase-move marker for the watchdog
	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rcv_st_r    <= slsb_pkg::RCV_RESTART;
			rcv_moved_r <= 1'b1;
		end else begin
			rcv_st_r    <= rcv_st_nxt;
			rcv_moved_r <= (rcv_st_nxt != rcv_st_r);
		end
	end

	// receive flags, sent to the send side over the back channel
	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			RX_ALIGNED    <= 1'b0;
			RX_BONDED     <= 1'b0;
			RX_VERIFY     <= 1'b0;
			RX_RESET      <= 1'b1;
			RX_CHANNEL_UP <= 1'b0;
		end else begin
			RX_ALIGNED    <= (rcv_st_r != slsb_pkg::RCV_RESTART) &&
				(rcv_st_r != slsb_pkg::RCV_ALIGN); // RULE1
			RX_BONDED     <= MULTI &&
				((rcv_st_r == slsb_pkg::RCV_VERIFY) ||
				(rcv_st_r == slsb_pkg::RCV_UP)); // RULE2
			RX_VERIFY     <= (rcv_st_r == slsb_pkg::RCV_UP);
			RX_RESET      <= (rcv_st_r == slsb_pkg::RCV_RESTART);
			RX_CHANNEL_UP <= (rcv_st_r == slsb_pkg::RCV_UP);
		end
	end

	// transceiver: control registered through, status mirrored after sync
	always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
		if (!rst_n_r) begin
			GT_POWER_DOWN    <= 1'b0;
			GT_LOOPBACK      <= 3'h0;
			TX_RESETDONE_OUT <= 1'b0;
			RX_RESETDONE_OUT <= 1'b0;
			TX_LOCK          <= 1'b0;
		end else begin
			GT_POWER_DOWN    <= POWER_DOWN; // RULE13
			GT_LOOPBACK      <= LOOPBACK; // RULE14
			TX_RESETDONE_OUT <= sync2_r[0]; // RULE15
			RX_RESETDONE_OUT <= sync2_r[1]; // RULE15
			TX_LOCK          <= sync2_r[2]; // RULE16
		end
	end

endmodule // slsb_top

/* tb/slsb_top_asserts.sv */
// assertion checker for the simplex startup sideband block
`timescale 1ns/10ps

module slsb_chk #(
	parameter int unsigned LANES            = 1,
	parameter logic [31:0] WATCHDOG_TIMEOUT = 32'h0000_01F4
) (
	// clock, reset and mode
	input wire logic       SYS_CLK,
	input wire logic       ARST_N,
	input wire logic       INIT_TIMED,
	// errors
	input wire logic       TX_HARD_ERR,
	input wire logic       RX_HARD_ERR,
	// sideband flags
	input wire logic       TX_ALIGNED,
	input wire logic       TX_BONDED,
	input wire logic       TX_VERIFY,
	input wire logic       TX_RESET,
	input wire logic       TX_CHANNEL_UP,
	input wire logic       RX_ALIGNED,
	input wire logic       RX_BONDED,
	input wire logic       RX_VERIFY,
	input wire logic       RX_RESET,
	input wire logic       RX_CHANNEL_UP,
	// transceiver control and status
	input wire logic       POWER_DOWN,
	input wire logic [2:0] LOOPBACK,
	input wire logic       GT_POWER_DOWN,
	input wire logic [2:0] GT_LOOPBACK,
	input wire logic       GT_TX_RESETDONE,
	input wire logic       TX_RESETDONE_OUT
);
	logic [3:0]  up_r;
	logic [4:0]  rxf_r;
	logic [31:0] still_r;

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);

	// history is only trusted once the two-flop reset release has settled
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			up_r <= 4'h0;
		else if (up_r != 4'h8)
			up_r <= up_r + 4'h1;
	end

	// dwell counter of a receive phase, rearmed on every flag change
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rxf_r   <= 5'h00;
			still_r <= 32'h0;
		end else begin
			rxf_r   <= {RX_RESET, RX_ALIGNED, RX_BONDED, RX_VERIFY,
				RX_CHANNEL_UP};
			still_r <= (rxf_r != {RX_RESET, RX_ALIGNED, RX_BONDED,
				RX_VERIFY, RX_CHANNEL_UP} || RX_RESET || RX_CHANNEL_UP) ?
				32'h0 : still_r + 32'h1;
		end
	end

	a_pd_follows: assert property (up_r == 4'h8 |->
		GT_POWER_DOWN == $past(POWER_DOWN)) else $error("power-down lag");
	a_loop_follows: assert property (up_r == 4'h8 |->
		GT_LOOPBACK == $past(LOOPBACK)) else $error("loopback lag");
	a_txdone_mirror: assert property (up_r == 4'h8 |->
		TX_RESETDONE_OUT == $past(GT_TX_RESETDONE, 3))
		else $error("reset-done mirror");
	a_bond_order: assert property (INIT_TIMED && $rose(TX_BONDED) |->
		TX_ALIGNED && !TX_VERIFY) else $error("bond out of order");
	a_verify_order: assert property (INIT_TIMED && $rose(TX_VERIFY) |->
		TX_ALIGNED && (TX_BONDED || LANES == 1) && TX_CHANNEL_UP)
		else $error("verify out of order");
	a_rx_err_reset: assert property (RX_HARD_ERR |-> ##2
		(RX_RESET && !RX_CHANNEL_UP)) else $error("rx error no restart");
	a_tx_err_reset: assert property (INIT_TIMED && TX_HARD_ERR |-> ##2
		(!TX_ALIGNED && !TX_VERIFY && !TX_CHANNEL_UP))
		else $error("tx error no restart");
	a_wdog_bound: assert property (
		still_r < WATCHDOG_TIMEOUT + 32'h8) else $error("phase stalled");

endmodule // slsb_chk

bind slsb_top slsb_chk #(.LANES(LANES),
	.WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT)) u_chk (
	.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .INIT_TIMED(INIT_TIMED),
	.TX_HARD_ERR(TX_HARD_ERR), .RX_HARD_ERR(RX_HARD_ERR),
	.TX_ALIGNED(TX_ALIGNED), .TX_BONDED(TX_BONDED), .TX_VERIFY(TX_VERIFY),
	.TX_RESET(TX_RESET), .TX_CHANNEL_UP(TX_CHANNEL_UP),
	.RX_ALIGNED(RX_ALIGNED), .RX_BONDED(RX_BONDED), .RX_VERIFY(RX_VERIFY),
	.RX_RESET(RX_RESET), .RX_CHANNEL_UP(RX_CHANNEL_UP),
	.POWER_DOWN(POWER_DOWN), .LOOPBACK(LOOPBACK),
	.GT_POWER_DOWN(GT_POWER_DOWN), .GT_LOOPBACK(GT_LOOPBACK),
	.GT_TX_RESETDONE(GT_TX_RESETDONE), .TX_RESETDONE_OUT(TX_RESETDONE_OUT));

/* tb/slsb_far_end.sv */
// far side model: receive lane progress and back channel wiring
`timescale 1ns/10ps

module slsb_far_end (
	// clock
	input  wire logic        clk,
	// bench control
	input  wire logic        en,
	input  wire logic [15:0] dly,
	// receive flags of the block
	input  wire logic        rx_rst,
	input  wire logic        rx_al,
	input  wire logic        rx_bo,
	input  wire logic        rx_ve,
	// lane progress and back channel pins
	output logic             ln_al,
	output logic             ln_bo,
	output logic             ln_ve,
	output logic [3:0]       bc
);
	int cnt = 0;

	// each phase needs dly more cycles; a large dly stalls the link
	always_ff @(posedge clk) begin
		cnt   <= (rx_rst || !en) ? 0 : cnt + 1;
		ln_al <= en && !rx_rst && cnt >= dly;
		ln_bo <= en && rx_al && cnt >= 2 * dly;
		ln_ve <= en && rx_bo && cnt >= 3 * dly;
	end

	// receive flags are reported on every change, one cycle of wire delay
	always_ff @(posedge clk) begin
		bc <= {rx_rst, rx_ve, rx_bo, rx_al};
	end

endmodule // slsb_far_end

/* tb/test_slsb_top.sv */
// self-checking bench of the simplex startup sideband block
`timescale 1ns/10ps

module test_slsb_top;
	localparam logic [31:0] BOND = 32'h14;
	localparam logic [31:0] VER  = 32'h28;
	localparam logic [31:0] WDOG = 32'h1F4;
	logic SYS_CLK, ARST_N, INIT_TIMED, REINIT_EN, TX_HARD_ERR, RX_HARD_ERR;
	logic POWER_DOWN, GT_TX_RESETDONE, GT_RX_RESETDONE, GT_PLL_LOCK, en;
	logic [2:0] LOOPBACK, GT_LOOPBACK;
	logic [3:0] bc;
	logic [15:0] dly;
	logic [6:0] v;
	logic [6:0] hq[$];
	logic ln_al, ln_bo, ln_ve, GT_POWER_DOWN, txd, rxd, lck;
	logic [9:0] fl;
	int failures = 0, comparisons = 0, n;

	slsb_top #(.LANES(2), .ALIGN_CYCLES(32'h14), .BOND_CYCLES(BOND),
		.VERIFY_CYCLES(VER), .WATCHDOG_TIMEOUT(WDOG),
		.REINIT_CYCLES(32'h12C)) dut (
		.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .INIT_TIMED(INIT_TIMED),
		.REINIT_EN(REINIT_EN), .BC_ALIGNED(bc[0]), .BC_BONDED(bc[1]),
		.BC_VERIFY(bc[2]), .BC_RESET(bc[3]), .TX_HARD_ERR(TX_HARD_ERR),
		.RX_HARD_ERR(RX_HARD_ERR), .RX_LANE_ALIGNED(ln_al),
		.RX_LANE_BONDED(ln_bo), .RX_LANE_VERIFIED(ln_ve),
		.TX_ALIGNED(fl[0]), .TX_BONDED(fl[1]), .TX_VERIFY(fl[2]),
		.TX_RESET(fl[3]), .TX_CHANNEL_UP(fl[4]), .RX_ALIGNED(fl[5]),
		.RX_BONDED(fl[6]), .RX_VERIFY(fl[7]), .RX_RESET(fl[8]),
		.RX_CHANNEL_UP(fl[9]), .POWER_DOWN(POWER_DOWN),
		.LOOPBACK(LOOPBACK), .GT_POWER_DOWN(GT_POWER_DOWN),
		.GT_LOOPBACK(GT_LOOPBACK), .GT_TX_RESETDONE(GT_TX_RESETDONE),
		.GT_RX_RESETDONE(GT_RX_RESETDONE), .GT_PLL_LOCK(GT_PLL_LOCK),
		.TX_RESETDONE_OUT(txd), .RX_RESETDONE_OUT(rxd), .TX_LOCK(lck));

	slsb_far_end far (.clk(SYS_CLK), .en(en), .dly(dly), .rx_rst(fl[8]),
		.rx_al(fl[5]), .rx_bo(fl[6]), .rx_ve(fl[7]), .ln_al(ln_al),
		.ln_bo(ln_bo), .ln_ve(ln_ve), .bc(bc));

	// free-running user clock
	initial begin
		SYS_CLK = 1'b0;
		forever #2 SYS_CLK = ~SYS_CLK;
	end

	task automatic chk(input string nm, input logic [9:0] e,
		input logic [9:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// bounded wait for one flag; the count doubles as a phase length
	task automatic waitf(input int i, input logic lv, input int lim);
		n = 0;
		while (fl[i] !== lv && n < lim) begin
			@(negedge SYS_CLK);
			n++;
		end
		chk("flag", {9'h0, lv}, {9'h0, fl[i]});
	endtask

	task automatic pulse(input logic tx);
		TX_HARD_ERR = tx;
		RX_HARD_ERR = !tx;
		@(negedge SYS_CLK);
		{TX_HARD_ERR, RX_HARD_ERR} = 2'h0;
		repeat (2) @(negedge SYS_CLK);
	endtask

	task automatic conclude();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// cuts a hang short after far more cycles than the tests need
	initial begin
		#160000;
		failures++;
		conclude();
	end

	initial begin
		{ARST_N, INIT_TIMED, REINIT_EN, TX_HARD_ERR, RX_HARD_ERR} = 5'h00;
		{POWER_DOWN, LOOPBACK, GT_TX_RESETDONE} = 5'h00;
		{GT_RX_RESETDONE, GT_PLL_LOCK, en} = 3'h0;
		dly = 16'h0005;
		n = $urandom(32'h81D8305C);
		repeat (6) @(negedge SYS_CLK);
		chk("reset", 10'h108, fl);
		ARST_N = 1'b1;
		repeat (4) @(negedge SYS_CLK);
		// transceiver pass-through against a history queue
		repeat (60) begin
			if (hq.size() > 3) begin
				chk("gtctl", {6'h0, hq[0][3:0]},
					{6'h0, GT_LOOPBACK, GT_POWER_DOWN});
				chk("status", {7'h0, hq[2][6:4]}, {7'h0, lck, rxd, txd});
				void'(hq.pop_back());
			end
			v = 7'($urandom);
			{GT_PLL_LOCK, GT_RX_RESETDONE, GT_TX_RESETDONE} = v[6:4];
			{LOOPBACK, POWER_DOWN} = v[3:0];
			hq.push_front(v);
			@(negedge SYS_CLK);
		end
		// timed send side while the far side never progresses
		INIT_TIMED = 1'b1;
		waitf(0, 1'b1, 400);
		chk("align", 10'h001, fl & 10'h01F);
		waitf(1, 1'b1, 400);
		chk("bondlen", 10'(n >= BOND && n <= BOND + 2), 10'h001);
		waitf(2, 1'b1, 400);
		chk("verlen", 10'(n >= VER && n <= VER + 2), 10'h001);
		chk("sendup", 10'h017, fl & 10'h01F);
		REINIT_EN = 1'b1;
		waitf(3, 1'b1, 1000);
		chk("clear", 10'h008, fl & 10'h01F);
		REINIT_EN = 1'b0;
		waitf(0, 1'b1, 400);
		pulse(1'b1);
		chk("txerr", 10'h000, fl & 10'h017);
		// back channel forwarding of a live receive side
		INIT_TIMED = 1'b0;
		en = 1'b1;
		waitf(9, 1'b1, 900);
		waitf(2, 1'b1, 8);
		chk("fwd", 10'h017, fl & 10'h01F);
		repeat (150) @(negedge SYS_CLK);
		chk("stay", 10'h200, fl & 10'h300);
		pulse(1'b0);
		chk("rxerr", 10'h100, fl & 10'h300);
		waitf(3, 1'b1, 8);
		waitf(9, 1'b1, 900);
		// stalled lane progress must trip the phase watchdog
		dly = 16'h07D0;
		pulse(1'b0);
		waitf(8, 1'b0, 100);
		waitf(8, 1'b1, 700);
		chk("wdog", 10'(n >= WDOG && n <= WDOG + 8), 10'h001);
		conclude();
	end

endmodule // test_slsb_top
